/* File: hdl/motor_start_path_select.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_start_path_select
	import motor_start_pkg::*;
#(
	parameter int MS_TICK = MS_CYCLES
)(
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_b_i,
	input  wire logic [ADDR_W-1:0]        addr_i,
	input  wire logic [DATA_W-1:0]        wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [DATA_W-1:0]        rdata_o,
	input  wire logic signed [DATA_W-1:0] motor_speed_i,
	input  wire logic [DATA_W-1:0]        torque_cmd_i,
	input  wire logic                     sense_done_i,
	input  wire logic                     open_loop_done_i,
	input  wire logic                     pll_locked_i,
	output logic      [DATA_W-1:0]        torque_ref_o,
	output logic                          catch_spin_o,
	output logic                          angle_sense_o,
	output logic                          open_loop_o,
	output logic                          run_o,
	output logic                          direct_start_o
);

	if (MS_TICK < 1) begin : g_bad_tick
		$error("MS_TICK must be at least one");
	end

	// ****************************************
	// Declarations
	// ****************************************
	logic              en_reg,     en_next;
	logic [DATA_W-1:0] dur_reg,    dur_next;
	logic [DATA_W-1:0] thr_reg,    thr_next;
	logic [DATA_W-1:0] itq_reg,    itq_next;
	logic [DATA_W-1:0] rdata_reg,  rdata_next;

	seq_state_e        state_reg,  state_next;
	logic              direct_reg, direct_next;
	logic              locked_reg, locked_next;

	logic [DATA_W-1:0] torque_reg, torque_next;
	logic              catch_reg,  catch_next;
	logic              sense_reg,  sense_next;
	logic              ol_reg,     ol_next;
	logic              run_reg,    run_next;

	logic [DATA_W-1:0] speed_abs;
	logic              direct_go;
	logic [DATA_W-1:0] status_word;

	start_if tmr_bus ();

	catch_spin_timer #(
		.TICK_CYCLES (MS_TICK)
	) u_timer (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.tmr        (tmr_bus.timer)
	);

	// ****************************************
	// Register file
	// ****************************************
	// Out-of-range writes clamp instead of wrapping, so a bad value
	// never turns into a tiny torque or threshold
	always_comb begin
		en_next  = en_reg;
		dur_next = dur_reg;
		thr_next = thr_reg;
		itq_next = itq_reg;
		if (wr_i) begin
			case (addr_i)
				ADDR_CTRL: begin
					en_next = wdata_i[CTRL_EN_BIT];
				end
				ADDR_CATCH: begin
					dur_next = wdata_i;
				end
				ADDR_THR: begin
					thr_next = (wdata_i > THR_MAX) ? THR_MAX : wdata_i;
				end
				ADDR_TORQUE: begin
					itq_next = (wdata_i > TORQUE_MAX) ? TORQUE_MAX : wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		status_word = '0;
		status_word[STAT_STATE_LSB +: 3] = state_reg;
		status_word[STAT_DIRECT_BIT]     = direct_reg;
		status_word[STAT_LOCKED_BIT]     = locked_reg;
		status_word[STAT_BUSY_BIT]       = tmr_bus.busy;
	end

	// Read data valid only in the cycle after the strobe, zero otherwise
	always_comb begin
		rdata_next = '0;
		if (rd_i) begin
			case (addr_i)
				ADDR_CTRL: begin
					rdata_next[CTRL_EN_BIT] = en_reg;
				end
				ADDR_STATUS: begin
					rdata_next = status_word;
				end
				ADDR_CATCH: begin
					rdata_next = dur_reg;
				end
				ADDR_THR: begin
					rdata_next = thr_reg;
				end
				ADDR_TORQUE: begin
					rdata_next = itq_reg;
				end
				default: begin
					rdata_next = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			en_reg    <= 1'b0;
			dur_reg   <= RST_CATCH;
			thr_reg   <= RST_THR;
			itq_reg   <= RST_TORQUE;
			rdata_reg <= RST_ZERO;
		end else begin
			en_reg    <= en_next;
			dur_reg   <= dur_next;
			thr_reg   <= thr_next;
			itq_reg   <= itq_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// Start sequencer
	// ****************************************
	// Magnitude of the signed speed; -32768 maps to 32768 unsigned
	assign speed_abs = motor_speed_i[DATA_W-1] ?
		DATA_W'(-motor_speed_i) : DATA_W'(motor_speed_i);

	assign direct_go = (thr_reg == RST_ZERO) ||
		(speed_abs >= thr_reg);

	always_comb begin
		state_next       = state_reg;
		direct_next      = direct_reg;
		locked_next      = locked_reg;
		tmr_bus.start    = 1'b0;
		tmr_bus.abort    = 1'b0;
		tmr_bus.duration = dur_reg;
		if (!en_reg) begin
			// Disable drops everything back to idle at once
			state_next    = ST_IDLE;
			direct_next   = 1'b0;
			locked_next   = 1'b0;
			tmr_bus.abort = 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					tmr_bus.start = 1'b1;
					state_next    = ST_CATCH;
					direct_next   = 1'b0;
					locked_next   = 1'b0;
				end
				ST_CATCH: begin
					if (tmr_bus.done) begin
						if (direct_go) begin
							state_next  = ST_RUN;
							direct_next = 1'b1;
						end else begin
							state_next = ST_SENSE;
						end
					end
				end
				ST_SENSE: begin
					if (sense_done_i) begin
						state_next = ST_PARK_OL;
					end
				end
				ST_PARK_OL: begin
					if (open_loop_done_i) begin
						state_next = ST_RUN;
					end
				end
				ST_RUN: begin
					if (pll_locked_i) begin
						locked_next = 1'b1;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	// Outputs follow the next state so they line up with state_reg
	always_comb begin
		torque_next = RST_ZERO;
		catch_next  = (state_next == ST_CATCH);
		sense_next  = (state_next == ST_SENSE);
		ol_next     = (state_next == ST_PARK_OL);
		run_next    = (state_next == ST_RUN);
		case (state_next)
			ST_PARK_OL: begin
				torque_next = itq_reg;
			end
			ST_RUN: begin
				// Direct start skips this: flux loop already tracks the rotor
				torque_next = (direct_next || locked_next) ?
					torque_cmd_i : itq_reg;
			end
			ST_CATCH: begin
				torque_next = RST_ZERO;
			end
			default: begin
				torque_next = RST_ZERO;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg  <= ST_IDLE;
			direct_reg <= 1'b0;
			locked_reg <= 1'b0;
			torque_reg <= RST_ZERO;
			catch_reg  <= 1'b0;
			sense_reg  <= 1'b0;
			ol_reg     <= 1'b0;
			run_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			direct_reg <= direct_next;
			locked_reg <= locked_next;
			torque_reg <= torque_next;
			catch_reg  <= catch_next;
			sense_reg  <= sense_next;
			ol_reg     <= ol_next;
			run_reg    <= run_next;
		end
	end

	assign rdata_o        = rdata_reg;
	assign torque_ref_o   = torque_reg;
	assign catch_spin_o   = catch_reg;
	assign angle_sense_o  = sense_reg;
	assign open_loop_o    = ol_reg;
	assign run_o          = run_reg;
	assign direct_start_o = direct_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_catch_end;
		state_reg == ST_CATCH && en_reg && tmr_bus.done;
	endsequence

	sequence s_sense_end;
		state_reg == ST_SENSE && en_reg && sense_done_i;
	endsequence

	sequence s_init_applied;
		open_loop_o && torque_ref_o == $past(itq_reg);
	endsequence

	AST_TORQUE_RANGE: assert property (
		itq_reg <= TORQUE_MAX)
		else $error("Initial torque above range");

	AST_INIT_AFTER_SENSE: assert property (
		s_sense_end |=> s_init_applied)
		else $error("Initial torque not applied after sensing");

	AST_RUN_INIT: assert property (
		(state_reg == ST_RUN && en_reg && !direct_reg && !locked_reg
		&& !pll_locked_i) |=> run_o && torque_ref_o == $past(itq_reg))
		else $error("Run began without initial torque");

	// Zero catch time gives a single catch cycle: entry and phase apart
	AST_CATCH_ENTRY: assert property (
		(state_reg == ST_IDLE && en_reg) |=>
		catch_spin_o && torque_ref_o == RST_ZERO)
		else $error("Catch spin not entered from idle");

	AST_CATCH_ZERO: assert property (
		(state_reg == ST_CATCH) |->
		(catch_spin_o && torque_ref_o == RST_ZERO))
		else $error("Torque not zero in catch spin");

	AST_THR_RANGE: assert property (
		thr_reg <= THR_MAX)
		else $error("Speed threshold above range");

	AST_SLOW_PATH: assert property (
		s_catch_end ##0 (thr_reg != RST_ZERO && speed_abs < thr_reg)
		|=> angle_sense_o && !run_o && !direct_start_o)
		else $error("Slow rotor did not take sensing path");

	AST_ZERO_THR: assert property (
		s_catch_end ##0 (thr_reg == RST_ZERO) |=> run_o && direct_start_o)
		else $error("Zero threshold did not go to run");

	AST_FAST_PATH: assert property (
		s_catch_end ##0 (speed_abs >= thr_reg) |=>
		run_o && direct_start_o && !angle_sense_o)
		else $error("Fast rotor did not go direct");

endmodule : motor_start_path_select
`default_nettype wire

/* File: hdl/motor_start_pkg.sv */
package motor_start_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;

	// ****************************************
	// Register map (register index on the port)
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_CATCH  = 8'h16;
	localparam logic [ADDR_W-1:0] ADDR_THR    = 8'h17;
	localparam logic [ADDR_W-1:0] ADDR_TORQUE = 8'h1D;

	localparam logic [DATA_W-1:0] RST_CATCH  = 16'h03E8;
	localparam logic [DATA_W-1:0] RST_THR    = 16'h03E8;
	localparam logic [DATA_W-1:0] RST_TORQUE = 16'h000E;
	localparam logic [DATA_W-1:0] RST_ZERO   = 16'h0000;

	// Largest accepted values; writes above are clamped
	localparam logic [DATA_W-1:0] TORQUE_MAX = 16'h1FFF;
	localparam logic [DATA_W-1:0] THR_MAX    = 16'h7FFF;

	// Scale points: 4096 = rated RMS current, 16384 = max speed
	localparam logic [DATA_W-1:0] TORQUE_FULL = 16'h1000;
	localparam logic [DATA_W-1:0] SPEED_FULL  = 16'h4000;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_EN_BIT     = 0;
	localparam int STAT_STATE_LSB  = 0;
	localparam int STAT_DIRECT_BIT = 3;
	localparam int STAT_LOCKED_BIT = 4;
	localparam int STAT_BUSY_BIT   = 5;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int CATCH_UNIT_NS = 1000000;
	localparam int MS_CYCLES     = CATCH_UNIT_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CATCH,
		ST_SENSE,
		ST_PARK_OL,
		ST_RUN
	} seq_state_e;

endpackage : motor_start_pkg

/* File: hdl/start_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface start_if
	import motor_start_pkg::*;
();
	logic              start;
	logic              abort;
	logic [DATA_W-1:0] duration;
	logic              busy;
	logic              done;

	modport ctrl  (output start, output abort, output duration,
		input busy, input done);
	modport timer (input start, input abort, input duration,
		output busy, output done);
endinterface : start_if
`default_nettype wire

/* File: hdl/catch_spin_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module catch_spin_timer
	import motor_start_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
)(
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	start_if.timer    tmr
);

	localparam int CNT_W = $clog2(TICK_CYCLES + 1);

	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least one");
	end

	logic              busy_reg, busy_next;
	logic              done_reg, done_next;
	logic [CNT_W-1:0]  pre_reg,  pre_next;
	logic [DATA_W-1:0] ms_reg,   ms_next;
	logic [DATA_W-1:0] dur_reg,  dur_next;

	// ****************************************
	// Millisecond counter
	// ****************************************
	// Duration latched at start so a write mid-phase cannot cut it short
	always_comb begin
		busy_next = busy_reg;
		done_next = 1'b0;
		pre_next  = pre_reg;
		ms_next   = ms_reg;
		dur_next  = dur_reg;
		if (tmr.abort) begin
			busy_next = 1'b0;
		end else if (tmr.start && !busy_reg) begin
			dur_next = tmr.duration;
			pre_next = '0;
			ms_next  = '0;
			if (tmr.duration == RST_ZERO) begin
				done_next = 1'b1;
			end else begin
				busy_next = 1'b1;
			end
		end else if (busy_reg) begin
			if (pre_reg == CNT_W'(TICK_CYCLES - 1)) begin
				pre_next = '0;
				ms_next  = ms_reg + 16'h0001;
				if (ms_reg + 16'h0001 == dur_reg) begin
					busy_next = 1'b0;
					done_next = 1'b1;
				end
			end else begin
				pre_next = pre_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			pre_reg  <= '0;
			ms_reg   <= '0;
			dur_reg  <= '0;
		end else begin
			busy_reg <= busy_next;
			done_reg <= done_next;
			pre_reg  <= pre_next;
			ms_reg   <= ms_next;
			dur_reg  <= dur_next;
		end
	end

	assign tmr.busy = busy_reg;
	assign tmr.done = done_reg;

	// ****************************************
	// Checks
	// ****************************************
	logic [31:0] busy_cyc_reg;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_cyc_reg <= '0;
		end else if (tmr.start && !busy_reg) begin
			busy_cyc_reg <= '0;
		end else if (busy_reg) begin
			busy_cyc_reg <= busy_cyc_reg + 32'h0000_0001;
		end
	end

	AST_CATCH_TIME: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(done_reg && dur_reg != RST_ZERO) |->
		busy_cyc_reg == 32'(dur_reg) * 32'(TICK_CYCLES))
		else $error("Catch spin phase length wrong");

	AST_ZERO_TIME: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(tmr.start && !busy_reg && !tmr.abort && tmr.duration == RST_ZERO)
		|=> done_reg && !busy_reg)
		else $error("Zero catch time did not end at once");

endmodule : catch_spin_timer
`default_nettype wire

/* File: test/tb_motor_start_path_select.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_motor_start_path_select;
	import motor_start_pkg::*;

	// ****************************************
	// Setup
	// ****************************************
	// Short tick keeps every catch spin a few cycles long
	localparam int                MS      = 2;
	localparam logic [DATA_W-1:0] INIT_TQ = 16'h0123;
	localparam logic [DATA_W-1:0] CMD_TQ  = 16'h0456;

	logic                     core_clk_i       = 1'b0;
	logic                     rst_b_i          = 1'b0;
	logic        [ADDR_W-1:0] addr_i           = 8'h00;
	logic        [DATA_W-1:0] wdata_i          = 16'h0000;
	logic                     wr_i             = 1'b0;
	logic                     rd_i             = 1'b0;
	logic        [DATA_W-1:0] rdata_o;
	logic signed [DATA_W-1:0] motor_speed_i    = 16'h0000;
	logic        [DATA_W-1:0] torque_cmd_i     = CMD_TQ;
	logic                     sense_done_i     = 1'b0;
	logic                     open_loop_done_i = 1'b0;
	logic                     pll_locked_i     = 1'b0;
	logic        [DATA_W-1:0] torque_ref_o;
	logic                     catch_spin_o;
	logic                     angle_sense_o;
	logic                     open_loop_o;
	logic                     run_o;
	logic                     direct_start_o;
	int                       mismatches       = 0;
	int                       cmp_count        = 0;
	int                       cycles           = 0;

	motor_start_path_select #(.MS_TICK(MS)) u_motor_start_path_select (
		.core_clk_i       (core_clk_i),
		.rst_b_i          (rst_b_i),
		.addr_i           (addr_i),
		.wdata_i          (wdata_i),
		.wr_i             (wr_i),
		.rd_i             (rd_i),
		.rdata_o          (rdata_o),
		.motor_speed_i    (motor_speed_i),
		.torque_cmd_i     (torque_cmd_i),
		.sense_done_i     (sense_done_i),
		.open_loop_done_i (open_loop_done_i),
		.pll_locked_i     (pll_locked_i),
		.torque_ref_o     (torque_ref_o),
		.catch_spin_o     (catch_spin_o),
		.angle_sense_o    (angle_sense_o),
		.open_loop_o      (open_loop_o),
		.run_o            (run_o),
		.direct_start_o   (direct_start_o)
	);

	always #10 core_clk_i = ~core_clk_i;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic close_out;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic chk(input logic [DATA_W-1:0] got,
		input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask : chk1

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge core_clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i   <= 1'b0;
		@(negedge core_clk_i);
		chk(rdata_o, e);
	endtask : rd

	// Waits for catch spin, checks zero torque and its length, then path
	task automatic go(input logic [DATA_W-1:0] dur, input logic [DATA_W-1:0] thr,
		input logic [DATA_W-1:0] spd, input logic dir);
		int k;
		int c;
		k = 0;
		c = 0;
		wr(ADDR_CATCH, dur);
		motor_speed_i <= spd;
		wr(ADDR_THR, thr);
		wr(ADDR_CTRL, 16'h0001);
		while (catch_spin_o !== 1'b1 && k < 40) begin
			@(negedge core_clk_i);
			k++;
		end
		while (catch_spin_o === 1'b1 && c < 200) begin
			chk(torque_ref_o, RST_ZERO);
			@(negedge core_clk_i);
			c++;
		end
		chk(16'(c), 16'(int'(dur) * MS + 1));
		chk1(angle_sense_o, !dir);
		chk1(run_o, dir);
		chk1(direct_start_o, dir);
		chk(torque_ref_o, dir ? CMD_TQ : RST_ZERO);
	endtask : go

	task automatic stop;
		wr(ADDR_CTRL, 16'h0000);
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk({11'h000, catch_spin_o, angle_sense_o, open_loop_o, run_o,
			direct_start_o}, 16'h0000);
		chk(torque_ref_o, RST_ZERO);
	endtask : stop

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic regs;
		rd(ADDR_CATCH, RST_CATCH);
		rd(ADDR_THR, RST_THR);
		rd(ADDR_TORQUE, RST_TORQUE);
		rd(8'h05, RST_ZERO);
		wr(ADDR_TORQUE, 16'hFFFF);
		rd(ADDR_TORQUE, TORQUE_MAX);
		wr(ADDR_TORQUE, TORQUE_FULL);
		rd(ADDR_TORQUE, TORQUE_FULL);
		wr(ADDR_THR, 16'hFFFF);
		rd(ADDR_THR, THR_MAX);
		wr(ADDR_THR, SPEED_FULL);
		rd(ADDR_THR, SPEED_FULL);
		wr(ADDR_STATUS, 16'hFFFF);
		rd(ADDR_STATUS, RST_ZERO);
		wr(ADDR_TORQUE, INIT_TQ);
	endtask : regs

	task automatic sense_path;
		go(16'h0001, 16'h0005, 16'h0003, 1'b0);
		@(posedge core_clk_i);
		sense_done_i <= 1'b1;
		@(posedge core_clk_i);
		sense_done_i <= 1'b0;
		@(negedge core_clk_i);
		chk1(open_loop_o, 1'b1);
		chk(torque_ref_o, INIT_TQ);
		@(posedge core_clk_i);
		open_loop_done_i <= 1'b1;
		@(posedge core_clk_i);
		open_loop_done_i <= 1'b0;
		@(negedge core_clk_i);
		chk1(run_o, 1'b1);
		chk1(direct_start_o, 1'b0);
		repeat (3) @(negedge core_clk_i);
		// Flux loop not locked yet, so start torque must hold
		chk(torque_ref_o, INIT_TQ);
		@(posedge core_clk_i);
		pll_locked_i <= 1'b1;
		@(posedge core_clk_i);
		pll_locked_i <= 1'b0;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(torque_ref_o, CMD_TQ);
		@(posedge core_clk_i);
		torque_cmd_i <= TORQUE_FULL;
		@(posedge core_clk_i);
		torque_cmd_i <= CMD_TQ;
		@(negedge core_clk_i);
		chk(torque_ref_o, TORQUE_FULL);
		stop();
	endtask : sense_path

	task automatic direct_paths;
		go(16'h0000, 16'h0005, 16'hFFFB, 1'b1);
		// Run state, direct path, no lock, timer idle
		rd(ADDR_STATUS, 16'h000C);
		rd(ADDR_CTRL, 16'h0001);
		stop();
		go(16'h0000, 16'h0005, 16'hFFFC, 1'b0);
		stop();
		go(16'h0002, 16'h0000, 16'h0000, 1'b1);
		stop();
	endtask : direct_paths

	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		regs();
		sense_path();
		direct_paths();
		close_out();
	end
endmodule : tb_motor_start_path_select
`default_nettype wire
